// ==== dv/flight_computer_model.sv ====
// serial link side of the flight computer: envelopes, link clock and word capture
// assumes the sequencer shifts on link clock rising edges and idles low
`timescale 1ns/100ps
`default_nettype none
module flight_computer_model (
  output logic serClk,
  output logic reqInner,
  output logic reqOuter,
  input wire logic serOut
);
  // link clock stands low between frames
  initial
  begin
    serClk = 1'b0;
    reqInner = 1'b0;
    reqOuter = 1'b0;
  end
  // one envelope per word, one 320 ns link period per bit
  task automatic read_word(input logic outer, output logic [14:0] w);
    #7; // step off the system clock edge the caller may have returned on
    reqInner = !outer;
    reqOuter = outer;
    #647;
    for (int i = 14; i >= 0; i--)
    begin
      w[i] = serOut;
      serClk = 1'b1;
      #160 serClk = 1'b0;
      #160;
    end
    reqInner = 1'b0;
    reqOuter = 1'b0;
    #400;
  endtask
endmodule
`default_nettype wire

// ==== dv/gimbal_seq_properties.sv ====
// port-level assertions for the gimbal mode and search sequencer
// assumes panel command pulses are spaced more than eight clocks apart
`timescale 1ns/100ps
`default_nettype none
module gimbal_seq_properties (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic reqInner,
  input wire logic reqOuter,
  input wire logic serOut,
  input wire logic pnlOff,
  input wire logic pnlAuto,
  input wire logic pnlHold,
  input wire logic signed [gimbal_pkg::VAL_W-1:0] handInner,
  input wire logic signed [gimbal_pkg::VAL_W-1:0] handOuter,
  input wire logic signed [gimbal_pkg::VAL_W-1:0] rateInner,
  input wire logic signed [gimbal_pkg::VAL_W-1:0] rateOuter,
  input wire logic powerOn,
  input wire logic shutterClosed,
  input wire logic autoMode,
  input wire logic manualMode,
  input wire logic innerPosLoop,
  input wire logic outerPosLoop,
  input wire logic errFromTelescope
);
  import gimbal_pkg::*;
  // everything here lives in the system clock domain
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);
  // eight quiet clocks cover the envelope synchroniser delay
  a_ser_idle: assert property ((!reqInner && !reqOuter)[*8] |-> !serOut)
    else $error("serial output active outside envelope");
  a_off_shut: assert property (!powerOn |-> shutterClosed && !autoMode && !manualMode)
    else $error("power off without shutter closed");
  a_manual_open: assert property (manualMode |-> !shutterClosed && !innerPosLoop && !outerPosLoop)
    else $error("manual mode with shutter or position loop");
  a_manual_hand: assert property ((manualMode && $stable(handInner) && $stable(handOuter))[*6]
    |-> rateInner == handInner && rateOuter == handOuter)
    else $error("hand input not routed to rate loops");
  // only a panel command may end manual mode
  a_manual_keep: assert property ((manualMode && !pnlOff && !pnlAuto && !pnlHold)[*8] |=> manualMode)
    else $error("manual mode displaced by computer");
  a_hold_lock: assert property (powerOn && !autoMode && !manualMode
    |-> shutterClosed && innerPosLoop && outerPosLoop)
    else $error("hold without shutter and both position loops");
  a_track_loops: assert property (errFromTelescope
    |-> autoMode && innerPosLoop && outerPosLoop && !shutterClosed)
    else $error("track without both position loops");
  a_sweep_rate: assert property (autoMode && !errFromTelescope && rateOuter != 0
    |-> (rateOuter == SWEEP_RATE || rateOuter == -SWEEP_RATE) && !outerPosLoop && innerPosLoop)
    else $error("search outer rate not the fixed sweep code");
endmodule
bind gimbal_mode_search_sequencer gimbal_seq_properties props (.*);
`default_nettype wire

// ==== dv/testbench.sv ====
// self-checking bench for the gimbal mode and search sequencer
// assumes the link model plays the flight computer's serial side
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import gimbal_pkg::*;
  localparam int FA = 0, FH = 1, OFF = 2, ON = 3, MAN = 4, AUT = 5, HLD = 6, ES = 7, TP = 8;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [8:0] cmd; // one bit per command pin
  wire logic fcAuto = cmd[0], fcHold = cmd[1], pnlOff = cmd[2], pnlOn = cmd[3], pnlManual = cmd[4];
  wire logic pnlAuto = cmd[5], pnlHold = cmd[6], endSearch = cmd[7], tlmPulse = cmd[8];
  logic starPresence, inRange, serClk, reqInner, reqOuter, serOut, powerOn, shutterClosed;
  logic autoMode, manualMode, starOut, innerPosLoop, outerPosLoop, errFromTelescope;
  logic [ENC_W-1:0] encInner, encOuter, tlmInner, tlmOuter;
  logic signed [VAL_W-1:0] handInner, handOuter, rateInner, rateOuter, dacInner, dacOuter;
  logic [AXI_AW-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int n_errors = 0;
  int compares = 0;
  int cyc = 0;
  gimbal_mode_search_sequencer dut (.*);
  flight_computer_model fc (.*);
  always #20 sys_clk = ~sys_clk;
  // hang guard, well above the six and a half thousand or so clocks the run needs
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_errors = n_errors + 1;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // command pins are edge triggered, so a short pulse then a quiet gap
  task automatic pulse(input int b);
    cmd[b] <= 1'b1;
    repeat (4) @(posedge sys_clk);
    cmd[b] <= 1'b0;
    repeat (16) @(posedge sys_clk);
  endtask
  // ready lines stay high, so only valids toggle between transfers
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge sys_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge sys_clk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    fork
      begin
        do @(posedge sys_clk); while (!s_axi_awready);
        s_axi_awvalid <= 1'b0;
      end
      begin
        do @(posedge sys_clk); while (!s_axi_wready);
        s_axi_wvalid <= 1'b0;
      end
    join
    do @(posedge sys_clk); while (!s_axi_bvalid);
    r = s_axi_bresp;
  endtask
  // polls the status state field; a state that never comes fails after 300 reads
  task automatic wait_st(input logic [2:0] s);
    logic [31:0] d;
    logic [1:0] r;
    for (int i = 0; i < 300; i++)
    begin
      axr(REG_STATUS, d, r);
      if (d[2:0] === s)
        break;
    end
    chk(d[2:0], s);
  endtask
  task automatic t_power();
    chk(powerOn, 0);
    pulse(ON);
    wait_st(3'h1);
    chk({powerOn, shutterClosed}, 2'b11);
    pulse(OFF);
    chk({powerOn, shutterClosed}, 2'b01);
    pulse(ON);
    $display("test power done");
  endtask
  task automatic t_serial();
    logic [ENC_W-1:0] w;
    fc.read_word(1'b0, w);
    chk(w, 15'h2000);
    fc.read_word(1'b1, w);
    chk(w, 15'h5a3c);
    @(posedge sys_clk);
    encOuter <= 15'h0f0f;
    pulse(TP);
    chk(tlmInner, 15'h2000);
    chk(tlmOuter, 15'h0f0f);
    $display("test serial done");
  endtask
  task automatic t_bus();
    logic [31:0] d;
    logic [1:0] r;
    axr(REG_DELAY, d, r);
    chk(d, 32'h9c4);
    axw(REG_DELAY, 32'h3c, r);
    chk(r, RESP_OKAY);
    axr(REG_DELAY, d, r);
    chk(d, 32'h3c);
    axr(8'h14, d, r);
    chk(r, RESP_SLVERR);
    axw(REG_STATUS, 32'h0, r);
    chk(r, RESP_SLVERR);
    $display("test bus done");
  endtask
  task automatic t_manual();
    handInner <= 16'sh0123;
    handOuter <= -16'sh0045;
    pulse(MAN);
    chk({manualMode, autoMode, shutterClosed}, 3'b100);
    chk(rateInner, 16'sh0123);
    chk(rateOuter, -16'sh0045);
    pulse(FA);
    pulse(FH);
    wait_st(3'h2);
    $display("test manual done");
  endtask
  task automatic t_auto();
    logic [31:0] d;
    logic [1:0] r;
    starPresence <= 1'b1;
    pulse(AUT);
    wait_st(3'h7);
    chk({starOut, errFromTelescope, innerPosLoop, outerPosLoop, shutterClosed}, 5'b11110);
    starPresence <= 1'b0;
    wait_st(3'h3);
    chk(starOut, 0);
    encInner <= 15'h2000 - 15'd300;
    wait_st(3'h4);
    chk({innerPosLoop, outerPosLoop}, 2'b10);
    chk(rateOuter == SWEEP_RATE || rateOuter == -SWEEP_RATE, 1);
    starPresence <= 1'b1;
    pulse(ES);
    axr(REG_STATUS, d, r);
    chk(d[2:0], 3'h6);
    wait_st(3'h7);
    $display("test auto done");
  endtask
  task automatic t_hold();
    pulse(TP);
    pulse(FH);
    wait_st(3'h1);
    chk({shutterClosed, innerPosLoop, outerPosLoop}, 3'b111);
    encInner <= encInner + 15'd3;
    encOuter <= encOuter - 15'd2;
    pulse(TP);
    chk(dacInner, -16'sh0003);
    chk(dacOuter, 16'sh0002);
    inRange <= 1'b1;
    pulse(FA);
    wait_st(3'h7);
    chk(shutterClosed, 0);
    pulse(FH);
    inRange <= 1'b0;
    pulse(FA);
    wait_st(3'h3);
    pulse(HLD);
    pulse(FA);
    wait_st(3'h1);
    pulse(OFF);
    wait_st(3'h0);
    $display("test hold done");
  endtask
  // crude gimbals follow the rate and dac commands through a whole fine and coarse raster
  task automatic t_raster();
    logic [31:0] d;
    logic [1:0] r;
    logic back = 1'b0; // return to centre seen
    pulse(ON);
    pulse(FA);
    for (int i = 0; i < 4000; i++)
    begin
      axr(REG_STATUS, d, r);
      encOuter <= encOuter + (rateOuter > 0 ? 15'd32 : rateOuter < 0 ? -15'd32 : 15'd0);
      encInner <= encInner + (dacInner > 0 ? 15'd4 : dacInner < 0 ? -15'd4 : 15'd0);
      if (d[2:0] === 3'h5)
        back = 1'b1;
      if (back && d[2:0] === 3'h3)
        break;
    end
    chk({back, d[11], d[2:0]}, 5'h1b);
    $display("test raster done");
  endtask
  initial
  begin
    cmd = '0;
    starPresence = 1'b0;
    inRange = 1'b0;
    encInner = 15'h2000;
    encOuter = 15'h5a3c;
    handInner = '0;
    handOuter = '0;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hf;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge sys_clk);
    t_power();
    t_serial();
    t_bus();
    t_manual();
    t_auto();
    t_hold();
    t_raster();
    wrap_up();
  end
endmodule
`default_nettype wire

// ==== rtl/gimbal_mode_search_sequencer.sv ====
// mode arbitration, raster search, hold registers and encoder readout of a gimballed tracker
// assumes all discretes and encoder words are asynchronous pins; software on AXI4-Lite
`timescale 1ns/100ps
`default_nettype none
module gimbal_mode_search_sequencer (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic serClk,
  input wire logic reqInner,
  input wire logic reqOuter,
  input wire logic fcAuto,
  input wire logic fcHold,
  input wire logic pnlOff,
  input wire logic pnlOn,
  input wire logic pnlManual,
  input wire logic pnlAuto,
  input wire logic pnlHold,
  input wire logic starPresence,
  input wire logic endSearch,
  input wire logic inRange,
  input wire logic tlmPulse,
  input wire logic [gimbal_pkg::ENC_W-1:0] encInner,
  input wire logic [gimbal_pkg::ENC_W-1:0] encOuter,
  input wire logic signed [gimbal_pkg::VAL_W-1:0] handInner,
  input wire logic signed [gimbal_pkg::VAL_W-1:0] handOuter,
  output logic serOut,
  output logic [gimbal_pkg::ENC_W-1:0] tlmInner,
  output logic [gimbal_pkg::ENC_W-1:0] tlmOuter,
  output logic powerOn,
  output logic shutterClosed,
  output logic autoMode,
  output logic manualMode,
  output logic starOut,
  output logic innerPosLoop,
  output logic outerPosLoop,
  output logic errFromTelescope,
  output logic signed [gimbal_pkg::VAL_W-1:0] rateInner,
  output logic signed [gimbal_pkg::VAL_W-1:0] rateOuter,
  output logic signed [gimbal_pkg::VAL_W-1:0] dacInner,
  output logic signed [gimbal_pkg::VAL_W-1:0] dacOuter,
  input wire logic [gimbal_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [gimbal_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import gimbal_pkg::*;

  // signed difference of two encoder words
  function automatic logic signed [VAL_W-1:0] delta(input logic [ENC_W-1:0] a, input logic [ENC_W-1:0] b);
    delta = signed'({1'b0, a}) - signed'({1'b0, b});
  endfunction

  // encoder word plus signed offset, wrapped to encoder width
  function automatic logic [ENC_W-1:0] offsetPos(input logic [ENC_W-1:0] a, input logic signed [VAL_W-1:0] d);
    logic [VAL_W-1:0] sum;
    sum = {1'b0, a} + d;
    offsetPos = sum[ENC_W-1:0];
  endfunction

  // pin synchronisers, stage a feeds only stage b
  logic [SYNC_W-1:0] pinA_r, pinB_r, pinC_r;
  logic [2*ENC_W-1:0] encA_r, encB_r;
  logic [2*VAL_W-1:0] handA_r, handB_r;
  wire [SYNC_W-1:0] pinRaw = {tlmPulse, inRange, endSearch, starPresence, pnlHold, pnlAuto, pnlManual,
    pnlOn, pnlOff, fcHold, fcAuto, reqOuter, reqInner, serClk};
  wire [SYNC_W-1:0] pin = pinB_r;
  wire [SYNC_W-1:0] rise = pinB_r & ~pinC_r; // edge detect between the second and third stages
  wire [ENC_W-1:0] encIn = encB_r[ENC_W-1:0];
  wire [ENC_W-1:0] encOut = encB_r[2*ENC_W-1:ENC_W];

  // two flops on every asynchronous input, a third on the single-bit pins for edge detect
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pinA_r <= '0;
      pinB_r <= '0;
      pinC_r <= '0;
      encA_r <= '0;
      encB_r <= '0;
      handA_r <= '0;
      handB_r <= '0;
    end
    else
    begin
      pinA_r <= pinRaw;
      pinB_r <= pinA_r;
      pinC_r <= pinB_r;
      encA_r <= {encOuter, encInner};
      encB_r <= encA_r;
      handA_r <= {handOuter, handInner};
      handB_r <= handA_r;
    end
  end

  // serial readout: index 0 inner, 1 outer
  logic [ENC_W-1:0] shift_r [2];
  logic [3:0] bitsLeft_r [2];
  logic [ENC_W-1:0] holdPos_r [2]; // last readout before hold
  logic serOut_r;
  st_e st_r;
  wire [1:0] reqLvl = {pin[P_REQ_OUT], pin[P_REQ_IN]};
  wire [1:0] reqRise = {rise[P_REQ_OUT], rise[P_REQ_IN]};
  wire holding = (st_r == ST_HOLD);
  wire [ENC_W-1:0] encG [2];
  assign encG[0] = encIn;
  assign encG[1] = encOut;
  // inner envelope wins if the computer ever overlaps the two
  wire serOut_nxt = reqLvl[0] ? (bitsLeft_r[0] != 4'h0) & shift_r[0][ENC_W-1] :
    reqLvl[1] ? (bitsLeft_r[1] != 4'h0) & shift_r[1][ENC_W-1] : 1'b0;

  // word captured at envelope start, shifted on each serial clock rise
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int g = 0; g < 2; g++)
      begin
        shift_r[g] <= '0;
        bitsLeft_r[g] <= 4'h0;
        holdPos_r[g] <= '0;
      end
      serOut_r <= 1'b0;
    end
    else
    begin
      serOut_r <= serOut_nxt;
      for (int g = 0; g < 2; g++)
      begin
        if (reqRise[g])
        begin
          shift_r[g] <= encG[g];
          bitsLeft_r[g] <= 4'(ENC_W);
        end
        else if (reqLvl[g] && rise[P_SCK] && bitsLeft_r[g] != 4'h0)
        begin
          shift_r[g] <= {shift_r[g][ENC_W-2:0], 1'b0};
          bitsLeft_r[g] <= bitsLeft_r[g] - 4'h1;
        end
        // every readout refreshes the hold word unless already holding
        if ((reqRise[g] || rise[P_TLM]) && !holding)
          holdPos_r[g] <= encG[g];
      end
    end
  end
  assign serOut = serOut_r;

  // telemetry parallel words, latched on the readout pulse
  logic [ENC_W-1:0] tlmIn_r, tlmOut_r;
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tlmIn_r <= '0;
      tlmOut_r <= '0;
    end
    else if (rise[P_TLM])
    begin
      tlmIn_r <= encIn;
      tlmOut_r <= encOut;
    end
  end
  assign tlmInner = tlmIn_r;
  assign tlmOuter = tlmOut_r;

  // command arbitration
  logic manLock_r, holdLock_r; // panel manual or hold currently in force
  logic coarse_r, dirUp_r;
  logic [ENC_W-1:0] ctrIn_r, ctrOut_r; // search centre
  logic signed [VAL_W-1:0] tgtOff_r; // inner offset from centre
  logic [VAL_W-1:0] dly_r, trackDelay_r;
  wire autoReq = rise[P_PNL_AUTO] | (rise[P_FC_AUTO] & ~manLock_r & ~holdLock_r);
  wire holdReq = rise[P_PNL_HOLD] | (rise[P_FC_HOLD] & ~manLock_r);
  wire inAuto = (st_r == ST_STEP) | (st_r == ST_SWEEP) | (st_r == ST_RETURN) | (st_r == ST_DELAY) |
    (st_r == ST_TRACK);
  wire inSearch = (st_r == ST_STEP) | (st_r == ST_SWEEP) | (st_r == ST_RETURN);
  wire goTrack = (st_r == ST_MANUAL & pin[P_STAR]) | (st_r == ST_HOLD & pin[P_IN_RANGE]);
  wire [ENC_W-1:0] tgtIn = offsetPos(ctrIn_r, tgtOff_r);
  wire signed [VAL_W-1:0] errIn = delta(tgtIn, encIn);
  wire settled = (errIn <= SETTLE_TOL) && (errIn >= -SETTLE_TOL);
  wire signed [VAL_W-1:0] outOff = delta(encOut, ctrOut_r);
  wire signed [VAL_W-1:0] outLim = coarse_r ? COARSE_OUT_LIM : FINE_OUT_LIM;
  wire signed [VAL_W-1:0] inHi = coarse_r ? COARSE_IN_HI : FINE_IN_HI;
  wire sweepDone = dirUp_r ? (outOff >= outLim) : (outOff <= -outLim);
  wire rowsDone = (tgtOff_r + IN_STEP) > inHi;

  // mode and search state machine
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_r <= ST_OFF;
      manLock_r <= 1'b0;
      holdLock_r <= 1'b0;
      coarse_r <= 1'b0;
      dirUp_r <= 1'b1;
      ctrIn_r <= '0;
      ctrOut_r <= '0;
      tgtOff_r <= '0;
      dly_r <= '0;
    end
    else if (rise[P_PNL_OFF])
    begin
      st_r <= ST_OFF;
      manLock_r <= 1'b0;
      holdLock_r <= 1'b0;
    end
    else if (st_r == ST_OFF)
    begin
      // only power-on is heard while unpowered
      if (rise[P_PNL_ON])
        st_r <= ST_HOLD;
    end
    else if (rise[P_PNL_MAN])
    begin
      st_r <= ST_MANUAL;
      manLock_r <= 1'b1;
      holdLock_r <= 1'b0;
    end
    else if (holdReq)
    begin
      st_r <= ST_HOLD;
      if (rise[P_PNL_HOLD])
      begin
        holdLock_r <= 1'b1;
        manLock_r <= 1'b0;
      end
    end
    else if (autoReq && !inAuto)
    begin
      manLock_r <= 1'b0;
      holdLock_r <= 1'b0;
      if (goTrack)
        st_r <= ST_TRACK;
      else
      begin
        st_r <= ST_STEP;
        coarse_r <= 1'b0;
        dirUp_r <= 1'b1;
        ctrIn_r <= encIn;
        ctrOut_r <= encOut;
        tgtOff_r <= -FINE_IN_LO;
      end
    end
    else if (autoReq && rise[P_PNL_AUTO])
    begin
      manLock_r <= 1'b0;
      holdLock_r <= 1'b0;
    end
    else if (inSearch && rise[P_END_SRCH])
    begin
      st_r <= ST_DELAY;
      dly_r <= trackDelay_r;
    end
    else
    begin
      case (st_r)
        ST_STEP:
          // inner gimbal walks to its row before the next sweep
          if (settled)
            st_r <= ST_SWEEP;
        ST_SWEEP:
          if (sweepDone)
          begin
            dirUp_r <= ~dirUp_r;
            if (!rowsDone)
            begin
              tgtOff_r <= tgtOff_r + IN_STEP;
              st_r <= ST_STEP;
            end
            else if (!coarse_r)
            begin
              coarse_r <= 1'b1;
              tgtOff_r <= -COARSE_IN_LO;
              st_r <= ST_STEP;
            end
            else
            begin
              tgtOff_r <= '0;
              st_r <= ST_RETURN;
            end
          end
        ST_RETURN:
          // back at start, then the coarse pattern alone again
          if (settled)
          begin
            tgtOff_r <= -COARSE_IN_LO;
            st_r <= ST_STEP;
          end
        ST_DELAY:
          if (dly_r == '0)
            st_r <= ST_TRACK;
          else
            dly_r <= dly_r - 16'h0001;
        ST_TRACK:
          // star lost: rerun fine then coarse about the last track point
          if (!pin[P_STAR])
          begin
            st_r <= ST_STEP;
            coarse_r <= 1'b0;
            dirUp_r <= 1'b1;
            ctrIn_r <= encIn;
            ctrOut_r <= encOut;
            tgtOff_r <= -FINE_IN_LO;
          end
        default:
          st_r <= st_r;
      endcase
    end
  end

  // servo configuration for the current mode
  wire [ENC_W-1:0] holdIn = holdPos_r[0];
  wire [ENC_W-1:0] holdOut = holdPos_r[1];
  wire signed [VAL_W-1:0] holdErrIn = delta(holdIn, encIn);
  wire signed [VAL_W-1:0] holdErrOut = delta(holdOut, encOut);
  wire isManual = (st_r == ST_MANUAL);
  wire isTrack = (st_r == ST_TRACK);
  wire innerPos_nxt = !isManual && (st_r != ST_OFF);
  wire outerPos_nxt = holding || isTrack;
  wire signed [VAL_W-1:0] rateIn_nxt = isManual ? signed'(handB_r[VAL_W-1:0]) : '0;
  wire signed [VAL_W-1:0] rateOut_nxt = isManual ? signed'(handB_r[2*VAL_W-1:VAL_W]) :
    (st_r == ST_SWEEP) ? (dirUp_r ? SWEEP_RATE : -SWEEP_RATE) : '0;
  wire signed [VAL_W-1:0] dacIn_nxt = holding ? holdErrIn :
    (inSearch || st_r == ST_DELAY) ? errIn : '0;
  wire signed [VAL_W-1:0] dacOut_nxt = holding ? holdErrOut : '0;

  // registered outputs
  logic power_r, shutter_r, auto_r, manual_r, star_r, inPos_r, outPos_r, tele_r;
  logic signed [VAL_W-1:0] rateIn_r, rateOut_r, dacIn_r, dacOut_r;
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      power_r <= 1'b0;
      shutter_r <= 1'b1;
      auto_r <= 1'b0;
      manual_r <= 1'b0;
      star_r <= 1'b0;
      inPos_r <= 1'b0;
      outPos_r <= 1'b0;
      tele_r <= 1'b0;
      rateIn_r <= '0;
      rateOut_r <= '0;
      dacIn_r <= '0;
      dacOut_r <= '0;
    end
    else
    begin
      power_r <= (st_r != ST_OFF);
      shutter_r <= (st_r == ST_OFF) || holding;
      auto_r <= inAuto;
      manual_r <= isManual;
      star_r <= pin[P_STAR];
      inPos_r <= innerPos_nxt;
      outPos_r <= outerPos_nxt;
      tele_r <= isTrack;
      rateIn_r <= rateIn_nxt;
      rateOut_r <= rateOut_nxt;
      dacIn_r <= dacIn_nxt;
      dacOut_r <= dacOut_nxt;
    end
  end
  assign powerOn = power_r;
  assign shutterClosed = shutter_r;
  assign autoMode = auto_r;
  assign manualMode = manual_r;
  assign starOut = star_r;
  assign innerPosLoop = inPos_r;
  assign outerPosLoop = outPos_r;
  assign errFromTelescope = tele_r;
  assign rateInner = rateIn_r;
  assign rateOuter = rateOut_r;
  assign dacInner = dacIn_r;
  assign dacOuter = dacOut_r;

  // axi4-lite slave; address and data may arrive in either order
  logic awHeld_r, wHeld_r, awRdy_r, wRdy_r, bValid_r, arRdy_r, rValid_r;
  logic [AXI_AW-1:0] awAddr_r;
  logic [31:0] wData_r, rData_r;
  logic [3:0] wStrb_r;
  logic [1:0] bResp_r, rResp_r;
  wire awTake = s_axi_awvalid & awRdy_r;
  wire wTake = s_axi_wvalid & wRdy_r;
  wire doWrite = awHeld_r & wHeld_r & ~bValid_r;
  wire bValid_nxt = doWrite | (bValid_r & ~s_axi_bready);
  wire awHeld_nxt = (awHeld_r | awTake) & ~doWrite;
  wire wHeld_nxt = (wHeld_r | wTake) & ~doWrite;
  wire arTake = s_axi_arvalid & arRdy_r;
  wire rValid_nxt = arTake | (rValid_r & ~s_axi_rready);
  wire wrDelay = (awAddr_r == REG_DELAY);
  wire [31:0] statusWord = {20'h00000, coarse_r, dirUp_r, manLock_r, holdLock_r, pin[P_STAR], shutter_r,
    power_r, auto_r, manual_r, st_r};
  wire rdKnown = (s_axi_araddr == REG_STATUS) || (s_axi_araddr == REG_INNER) ||
    (s_axi_araddr == REG_OUTER) || (s_axi_araddr == REG_DELAY) || (s_axi_araddr == REG_HOLD_ERR);
  wire [31:0] rdWord = (s_axi_araddr == REG_STATUS) ? statusWord :
    (s_axi_araddr == REG_INNER) ? {17'h00000, encIn} :
    (s_axi_araddr == REG_OUTER) ? {17'h00000, encOut} :
    (s_axi_araddr == REG_DELAY) ? {16'h0000, trackDelay_r} :
    (s_axi_araddr == REG_HOLD_ERR) ? {holdErrOut, holdErrIn} : 32'h00000000;

  // bus handshakes and the one writable register
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awRdy_r <= 1'b0;
      wRdy_r <= 1'b0;
      bValid_r <= 1'b0;
      bResp_r <= RESP_OKAY;
      arRdy_r <= 1'b0;
      rValid_r <= 1'b0;
      rResp_r <= RESP_OKAY;
      rData_r <= '0;
      awAddr_r <= '0;
      wData_r <= '0;
      wStrb_r <= 4'h0;
      trackDelay_r <= TRACK_DELAY_CYC;
    end
    else
    begin
      awHeld_r <= awHeld_nxt;
      wHeld_r <= wHeld_nxt;
      bValid_r <= bValid_nxt;
      rValid_r <= rValid_nxt;
      // each ready only while its own channel has nothing parked and no response is awaited
      awRdy_r <= ~awHeld_nxt & ~bValid_nxt;
      wRdy_r <= ~wHeld_nxt & ~bValid_nxt;
      arRdy_r <= ~rValid_nxt;
      if (awTake)
        awAddr_r <= s_axi_awaddr;
      if (wTake)
      begin
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end
      if (doWrite)
      begin
        // only the track delay is writable; the rest answer slverr
        bResp_r <= wrDelay ? RESP_OKAY : RESP_SLVERR;
        if (wrDelay && wStrb_r[0])
          trackDelay_r[7:0] <= wData_r[7:0];
        if (wrDelay && wStrb_r[1])
          trackDelay_r[15:8] <= wData_r[15:8];
      end
      if (arTake)
      begin
        rData_r <= rdWord;
        rResp_r <= rdKnown ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end
  assign s_axi_awready = awRdy_r;
  assign s_axi_wready = wRdy_r;
  assign s_axi_bvalid = bValid_r;
  assign s_axi_bresp = bResp_r;
  assign s_axi_arready = arRdy_r;
  assign s_axi_rvalid = rValid_r;
  assign s_axi_rdata = rData_r;
  assign s_axi_rresp = rResp_r;
endmodule
`default_nettype wire

// ==== rtl/gimbal_pkg.sv ====
// constants, states and register map of the gimbal mode and search sequencer
// assumes a 25 MHz system clock and 15-bit encoders at 30 arc seconds per count
package gimbal_pkg;
  localparam int ENC_W = 15;
  localparam int VAL_W = 16;
  localparam int AXI_AW = 8;
  localparam int SYS_CLK_MHZ = 25;
  // register byte addresses
  localparam logic [AXI_AW-1:0] REG_STATUS = 8'h00;
  localparam logic [AXI_AW-1:0] REG_INNER = 8'h04;
  localparam logic [AXI_AW-1:0] REG_OUTER = 8'h08;
  localparam logic [AXI_AW-1:0] REG_DELAY = 8'h0c;
  localparam logic [AXI_AW-1:0] REG_HOLD_ERR = 8'h10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // angles in encoder counts, 30 arc seconds each
  localparam int CNT_PER_DEG = 120;
  localparam logic signed [VAL_W-1:0] FINE_OUT_LIM = 16'(2 * CNT_PER_DEG);
  localparam logic signed [VAL_W-1:0] COARSE_OUT_LIM = 16'(15 * CNT_PER_DEG);
  localparam logic signed [VAL_W-1:0] FINE_IN_LO = 16'(5 * CNT_PER_DEG / 2);
  localparam logic signed [VAL_W-1:0] FINE_IN_HI = 16'(5 * CNT_PER_DEG / 2);
  localparam logic signed [VAL_W-1:0] COARSE_IN_LO = 16'(19 * CNT_PER_DEG / 4);
  localparam logic signed [VAL_W-1:0] COARSE_IN_HI = 16'(23 * CNT_PER_DEG / 4);
  localparam logic signed [VAL_W-1:0] IN_STEP = 16'(3 * CNT_PER_DEG / 4);
  localparam logic signed [VAL_W-1:0] SETTLE_TOL = 16'sh0002;
  // rate loop code for one degree per second
  localparam logic signed [VAL_W-1:0] SWEEP_RATE = 16'sh0100;
  // settling pause between end of search and track
  localparam int TRACK_DELAY_US = 100;
  localparam logic [VAL_W-1:0] TRACK_DELAY_CYC = 16'(TRACK_DELAY_US * SYS_CLK_MHZ);
  // bit positions of the synchronised single-bit pins
  localparam int SYNC_W = 14;
  localparam int P_SCK = 0;
  localparam int P_REQ_IN = 1;
  localparam int P_REQ_OUT = 2;
  localparam int P_FC_AUTO = 3;
  localparam int P_FC_HOLD = 4;
  localparam int P_PNL_OFF = 5;
  localparam int P_PNL_ON = 6;
  localparam int P_PNL_MAN = 7;
  localparam int P_PNL_AUTO = 8;
  localparam int P_PNL_HOLD = 9;
  localparam int P_STAR = 10;
  localparam int P_END_SRCH = 11;
  localparam int P_IN_RANGE = 12;
  localparam int P_TLM = 13;
  typedef enum logic [2:0] {ST_OFF, ST_HOLD, ST_MANUAL, ST_STEP, ST_SWEEP, ST_RETURN, ST_DELAY, ST_TRACK} st_e;
endpackage
